// ---- rtl/sprc_map.vh ----
/*
  Constants of the sleep, clock gating and reset control block: register
  indices and byte addresses, field positions, reset values, sleep mode
  codes, peripheral slot numbers and timing counts.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SPRC_MAP_VH
`define SPRC_MAP_VH

// Register indices; byte address is four times the index
`define SPRC_IDX_SLEEP_CTL 8'h50
`define SPRC_IDX_GATE_A 8'h51
`define SPRC_IDX_STATUS 8'h52
`define SPRC_IDX_GATE_B 8'h65
`define SPRC_ADDR_SLEEP_CTL {2'b00, `SPRC_IDX_SLEEP_CTL, 2'b00}
`define SPRC_ADDR_GATE_A {2'b00, `SPRC_IDX_GATE_A, 2'b00}
`define SPRC_ADDR_STATUS {2'b00, `SPRC_IDX_STATUS, 2'b00}
`define SPRC_ADDR_GATE_B {2'b00, `SPRC_IDX_GATE_B, 2'b00}

// Sleep control fields, register reset values and the reserved bit of gate A
`define SPRC_SE_BIT 0
`define SPRC_SM_LSB 1
`define SPRC_SM_MSB 3
`define SPRC_SLEEP_CTL_RST 4'h0
`define SPRC_GATE_A_RST 8'h00
`define SPRC_GATE_B_RST 6'h00
`define SPRC_GATE_A_RES_BIT 4

// Sleep mode codes
`define SPRC_SM_IDLE 3'h0
`define SPRC_SM_NOISE 3'h1
`define SPRC_SM_DOWN 3'h2
`define SPRC_SM_SAVE 3'h3
`define SPRC_SM_RES4 3'h4
`define SPRC_SM_RES5 3'h5
`define SPRC_SM_STBY 3'h6
`define SPRC_SM_XSTBY 3'h7

// Peripheral slots of the clock enable vector
`define SPRC_NPERIPH 13
`define SPRC_PI_CONV 0
`define SPRC_PI_SP0 1
`define SPRC_PI_SPI 2
`define SPRC_PI_TIM1 3
`define SPRC_PI_TIM0 4
`define SPRC_PI_TIM2 5
`define SPRC_PI_TWI 6

// Timing
`define SPRC_CLK_KHZ 10000
`define SPRC_TOUT0_US 1
`define SPRC_TOUT1_US 100
`define SPRC_TOUT2_US 1000
`define SPRC_TOUT3_US 10000
`define SPRC_US_TO_CK(us) (((us) * `SPRC_CLK_KHZ + 999) / 1000)
`define SPRC_TOUT_EXTRA_CK 20'h0_0040
`define SPRC_WAKE_STBY_CK 4'h6
`define SPRC_WAKE_OTHER_CK 4'h1

`endif

// ---- rtl/sprc_stretch.v ----
/*
  Reset stretch counter: holds the internal reset while any source is
  active and for a fuse-selected number of cycles after the last goes away.
  Assumes hold is the asynchronous merge of all reset sources.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sprc_map.vh"

module sprc_stretch #(
  parameter CNT_W = 20,
  parameter [19:0] T0_CK = `SPRC_US_TO_CK(`SPRC_TOUT0_US),
  parameter [19:0] T1_CK = `SPRC_US_TO_CK(`SPRC_TOUT1_US),
  parameter [19:0] T2_CK = `SPRC_US_TO_CK(`SPRC_TOUT2_US),
  parameter [19:0] T3_CK = `SPRC_US_TO_CK(`SPRC_TOUT3_US)
) (
  input wire clk,
  input wire hold,
  input wire [1:0] startup_time_fuses,
  input wire extra_sel,
  output reg busy_r
);

  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] target;

  // Period picked by the start-up fuses, lengthened by the clock select
  always @*
  begin
    case (startup_time_fuses)
      2'b00: target = T0_CK[CNT_W-1:0];
      2'b01: target = T1_CK[CNT_W-1:0];
      2'b10: target = T2_CK[CNT_W-1:0];
      default: target = T3_CK[CNT_W-1:0];
    endcase
    if (extra_sel)
    begin
      target = target + `SPRC_TOUT_EXTRA_CK;
    end
  end

  // Asynchronous hold; counting starts once the last source falls
  always @(posedge clk or posedge hold)
  begin
    if (hold)
    begin
      cnt_r <= {CNT_W{1'b0}};
      busy_r <= 1'b1;
    end
    else if (busy_r)
    begin
      if (cnt_r >= target - 1'b1)
      begin
        busy_r <= 1'b0;
      end
      else
      begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ---- rtl/sprc_top.v ----
/*
  Sleep mode, peripheral clock gating and reset merge control with an APB
  register slave.
  Assumes a core that pulses sleep_instr for one cycle per sleep
  instruction and analog detectors that deliver clean digital levels.
*/
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "sprc_map.vh"

module sprc_top #(
  parameter [19:0] T0_CK = `SPRC_US_TO_CK(`SPRC_TOUT0_US),
  parameter [19:0] T1_CK = `SPRC_US_TO_CK(`SPRC_TOUT1_US),
  parameter [19:0] T2_CK = `SPRC_US_TO_CK(`SPRC_TOUT2_US),
  parameter [19:0] T3_CK = `SPRC_US_TO_CK(`SPRC_TOUT3_US)
) (
  input wire clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sleep_instr,
  input wire wake_event,
  input wire timer_two_async_select,
  input wire [1:0] startup_time_fuses,
  input wire [3:0] clock_select_fuses,
  input wire por_active,
  input wire ext_reset_pin_b,
  input wire wdt_reset_pulse,
  input wire supply_drop_detector_en,
  input wire supply_drop_low,
  input wire scan_reset_reg,
  output reg sleep_active,
  output reg [2:0] sleep_mode,
  output reg sleep_refused,
  output reg [`SPRC_NPERIPH-1:0] periph_clk_en,
  output reg comparator_mux_ok,
  output reg sys_reset,
  output reg start_at_vector
);

  localparam [2:0] ST_RUN = 3'b001;
  localparam [2:0] ST_SLEEP = 3'b010;
  localparam [2:0] ST_WAKE = 3'b100;

  wire src_any;
  wire hold;
  wire stretch_busy;
  wire reg_rst_b;
  reg stretch_q_r;
  reg [3:0] sleep_ctl_r;
  reg [7:0] gate_a_r;
  reg [5:0] gate_b_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [3:0] wake_cnt_r;
  reg [3:0] wake_cnt_nxt;
  reg [2:0] mode_r;
  reg [2:0] mode_nxt;
  wire [2:0] sm_field;
  wire se_bit;
  wire sm_reserved;
  wire [`SPRC_NPERIPH-1:0] gate_all;
  wire [`SPRC_NPERIPH-1:0] en_nxt;
  wire apb_access;
  wire apb_done;
  wire addr_ok;
  reg [31:0] rd_mux;
  wire rd_cap;
  wire wake_long;
  wire [7:0] status_byte;
  wire hit_sleep_ctl;
  wire hit_gate_a;
  wire hit_gate_b;

  // Reset merge of all five sources, asynchronous to the clock
  assign src_any = por_active
    | ~ext_reset_pin_b
    | wdt_reset_pulse
    | (supply_drop_detector_en & supply_drop_low)
    | scan_reset_reg;
  assign hold = src_any | ~rst_b;

  sprc_stretch #(
    .CNT_W(20),
    .T0_CK(T0_CK),
    .T1_CK(T1_CK),
    .T2_CK(T2_CK),
    .T3_CK(T3_CK)
  ) u_stretch (
    .clk(clk),
    .hold(hold),
    .startup_time_fuses(startup_time_fuses),
    .extra_sel(clock_select_fuses[0]),
    .busy_r(stretch_busy)
  );

  // Registers stay at their initial values for the whole stretched reset
  assign reg_rst_b = ~stretch_busy;

  // Internal reset output and the restart pulse at its release
  always @(posedge clk or posedge hold)
  begin
    if (hold)
    begin
      sys_reset <= 1'b1;
      stretch_q_r <= 1'b1;
      start_at_vector <= 1'b0;
    end
    else
    begin
      sys_reset <= stretch_busy;
      stretch_q_r <= stretch_busy;
      start_at_vector <= stretch_q_r & ~stretch_busy;
    end
  end

  // Sleep control decode
  assign sm_field = sleep_ctl_r[`SPRC_SM_MSB:`SPRC_SM_LSB];
  assign se_bit = sleep_ctl_r[`SPRC_SE_BIT];
  assign sm_reserved = (sm_field == `SPRC_SM_RES4)
    | (sm_field == `SPRC_SM_RES5);
  // Both standby modes keep the oscillator running and wake more slowly
  assign wake_long = (mode_r == `SPRC_SM_STBY)
    | (mode_r == `SPRC_SM_XSTBY);

  // Sleep state machine
  always @*
  begin
    state_nxt = state_r;
    wake_cnt_nxt = wake_cnt_r;
    mode_nxt = mode_r;
    case (state_r)
      ST_RUN:
      begin
        if (sleep_instr & se_bit & ~sm_reserved)
        begin
          state_nxt = ST_SLEEP;
          mode_nxt = sm_field;
        end
      end
      ST_SLEEP:
      begin
        if (wake_event)
        begin
          state_nxt = ST_WAKE;
          if (wake_long)
          begin
            wake_cnt_nxt = `SPRC_WAKE_STBY_CK - 4'h1;
          end
          else
          begin
            wake_cnt_nxt = `SPRC_WAKE_OTHER_CK - 4'h1;
          end
        end
      end
      ST_WAKE:
      begin
        if (wake_cnt_r == 4'h0)
        begin
          state_nxt = ST_RUN;
        end
        else
        begin
          wake_cnt_nxt = wake_cnt_r - 4'h1;
        end
      end
      default:
      begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always @(posedge clk or negedge reg_rst_b)
  begin
    if (!reg_rst_b)
    begin
      state_r <= ST_RUN;
      wake_cnt_r <= 4'h0;
      mode_r <= `SPRC_SM_IDLE;
      sleep_active <= 1'b0;
      sleep_mode <= `SPRC_SM_IDLE;
      sleep_refused <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      wake_cnt_r <= wake_cnt_nxt;
      mode_r <= mode_nxt;
      sleep_active <= (state_nxt != ST_RUN);
      sleep_mode <= mode_nxt;
      sleep_refused <= (state_r == ST_RUN) & sleep_instr
        & (~se_bit | sm_reserved);
    end
  end

  // Clock enables; bit 4 of gate A has no peripheral
  assign gate_all = {gate_b_r, gate_a_r[7:5], gate_a_r[3:0]};

  genvar gi;
  generate
    for (gi = 0; gi < `SPRC_NPERIPH; gi = gi + 1)
    begin : g_periph
      wire stop;
      wire run_ok;
      if (gi == `SPRC_PI_TIM2)
      begin : g_tim2
        // An asynchronously clocked timer two ignores its gate bit here; sleep still stops it
        assign stop = gate_all[gi] & ~timer_two_async_select;
      end
      else
      begin : g_other
        assign stop = gate_all[gi];
      end
      if (gi == `SPRC_PI_CONV)
      begin : g_conv
        assign run_ok = (state_r == ST_RUN) | (mode_r == `SPRC_SM_IDLE)
          | (mode_r == `SPRC_SM_NOISE);
      end
      else
      begin : g_plain
        assign run_ok = (state_r == ST_RUN) | (mode_r == `SPRC_SM_IDLE);
      end
      // Enable only gates the clock, so module state is kept as it was
      assign en_nxt[gi] = ~stop & run_ok;
    end
  endgenerate

  always @(posedge clk or negedge reg_rst_b)
  begin
    if (!reg_rst_b)
    begin
      periph_clk_en <= {`SPRC_NPERIPH{1'b1}};
      comparator_mux_ok <= 1'b1;
    end
    else
    begin
      periph_clk_en <= en_nxt;
      comparator_mux_ok <= ~gate_a_r[`SPRC_PI_CONV];
    end
  end

  // APB slave: one wait state, pready from a flop
  assign apb_access = psel & penable;
  assign apb_done = apb_access & pready;
  assign addr_ok = (paddr == `SPRC_ADDR_SLEEP_CTL)
    | (paddr == `SPRC_ADDR_GATE_A)
    | (paddr == `SPRC_ADDR_STATUS)
    | (paddr == `SPRC_ADDR_GATE_B);
  assign rd_cap = apb_access & ~pready;
  assign hit_sleep_ctl = (paddr == `SPRC_ADDR_SLEEP_CTL);
  assign hit_gate_a = (paddr == `SPRC_ADDR_GATE_A);
  assign hit_gate_b = (paddr == `SPRC_ADDR_GATE_B);
  // Status: async select, reserved field, one-hot state, latched mode
  assign status_byte = {timer_two_async_select, sm_reserved, state_r,
    mode_r};

  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `SPRC_ADDR_SLEEP_CTL:
      begin
        rd_mux = {28'h000_0000, sleep_ctl_r};
      end
      `SPRC_ADDR_GATE_A:
      begin
        rd_mux = {24'h00_0000, gate_a_r[7:5], 1'b0,
          gate_a_r[3:0]};
      end
      `SPRC_ADDR_STATUS:
      begin
        rd_mux = {24'h00_0000, status_byte};
      end
      `SPRC_ADDR_GATE_B:
      begin
        rd_mux = {24'h00_0000, 2'b00, gate_b_r};
      end
      default:
      begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clk or negedge reg_rst_b)
  begin
    if (!reg_rst_b)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= rd_cap;
      if (rd_cap)
      begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= ~addr_ok;
      end
      else if (apb_done)
      begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // Register writes take effect at the completing edge only
  always @(posedge clk or negedge reg_rst_b)
  begin
    if (!reg_rst_b)
    begin
      sleep_ctl_r <= `SPRC_SLEEP_CTL_RST;
      gate_a_r <= `SPRC_GATE_A_RST;
      gate_b_r <= `SPRC_GATE_B_RST;
    end
    else if (apb_done & pwrite)
    begin
      if (hit_sleep_ctl)
      begin
        sleep_ctl_r <= pwdata[3:0];
      end
      if (hit_gate_a)
      begin
        gate_a_r <= pwdata[7:0] & 8'hEF;
      end
      if (hit_gate_b)
      begin
        gate_b_r <= pwdata[5:0];
      end
    end
  end

endmodule

`default_nettype wire

// ---- verif/sprc_checker.sv ----
/* Port checker for sprc_top.
   Assumes stretch counts of at most eight cycles. */
`timescale 1ns/10ps
`default_nettype none
module sprc_checker (
  input wire clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire sleep_instr,
  input wire por_active,
  input wire ext_reset_pin_b,
  input wire wdt_reset_pulse,
  input wire supply_drop_detector_en,
  input wire supply_drop_low,
  input wire scan_reset_reg,
  input wire sleep_active,
  input wire [2:0] sleep_mode,
  input wire sleep_refused,
  input wire sys_reset,
  input wire start_at_vector
);
  wire src;
  assign src = por_active | !ext_reset_pin_b | wdt_reset_pulse |
    (supply_drop_detector_en & supply_drop_low) | scan_reset_reg;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  property p_ready;
    psel && $rose(penable) && !sys_reset |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("late ready");
  property p_unmap;
    pready && !(paddr inside {12'h140, 12'h144, 12'h148, 12'h194})
      |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped accepted");
  property p_res_a;
    pready && !pwrite && paddr == 12'h144 |-> !prdata[4];
  endproperty
  a_res_a: assert property (p_res_a) else $error("gate a bit4");
  property p_res_b;
    pready && !pwrite && paddr == 12'h194 |-> prdata[31:6] == 26'h0;
  endproperty
  a_res_b: assert property (p_res_b) else $error("gate b 7:6");
  property p_entry;
    $rose(sleep_active) |-> $past(sleep_instr);
  endproperty
  a_entry: assert property (p_entry) else $error("stray sleep");
  property p_refuse;
    sleep_refused |-> $past(sleep_instr) && !sleep_active;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad refuse");
  property p_mode;
    sleep_active |-> sleep_mode[2:1] != 2'b10;
  endproperty
  a_mode: assert property (p_mode) else $error("reserved mode");
  property p_async;
    src |-> sys_reset;
  endproperty
  a_async: assert property (p_async) else $error("no reset");
  property p_stretch;
    $fell(src) |-> sys_reset [*2] ##[1:8] !sys_reset;
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch");
  property p_vector;
    $fell(sys_reset) |-> ##[0:1] start_at_vector;
  endproperty
  a_vector: assert property (p_vector) else $error("no vector");
endmodule
bind sprc_top sprc_checker i_chk (.*);
`default_nettype wire

// ---- verif/sprc_core.sv ----
/* Core model: APB master and sleep instruction source.
   Assumes the one wait state APB slave of sprc_top. */
`timescale 1ns/10ps
`default_nettype none
module sprc_core (
  input wire logic clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic sleep_active,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [11:0] paddr,
  output var logic [31:0] pwdata,
  output var logic sleep_instr,
  output var logic wake_event
);
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {sleep_instr, wake_event} = 2'b00;
  end
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Standby codes only issued as if a crystal clock is fitted
  task automatic slp(input logic [2:0] m, input logic en);
    logic [31:0] q;
    logic e;
    xfer(1'b1, 12'h140, {28'h0, m, en}, q, e);
    @(posedge clk);
    sleep_instr <= 1'b1;
    @(posedge clk);
    sleep_instr <= 1'b0;
  endtask
  task automatic wake();
    logic [31:0] q;
    logic e;
    @(posedge clk);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    for (int i = 0; i < 20 && sleep_active !== 1'b0; i++)
      @(posedge clk);
    xfer(1'b1, 12'h140, 32'h0, q, e);
  endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
/* Self-checking bench for sprc_top.
   Assumes short stretch parameters and clock select fuses at zero. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, rst_b, asel, por, pin_b, wdt, sd_en, sd_low, scan;
  logic psel, penable, pwrite, pready, pslverr, sins, wake, e;
  logic act, rf, vec, cmp, sysr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] mode;
  logic [12:0] en;
  logic [1:0] fuse;
  localparam logic [19:0] t0_ck = 20'h0_0002;
  localparam logic [19:0] t1_ck = 20'h0_0004;
  int mismatches, check_count, cyc;
  sprc_top #(.T0_CK(t0_ck), .T1_CK(t1_ck), .T2_CK(20'd8), .T3_CK(20'd16))
  i_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_instr(sins),
    .wake_event(wake), .timer_two_async_select(asel),
    .startup_time_fuses(fuse), .clock_select_fuses(4'h0),
    .por_active(por), .ext_reset_pin_b(pin_b), .wdt_reset_pulse(wdt),
    .supply_drop_detector_en(sd_en), .supply_drop_low(sd_low),
    .scan_reset_reg(scan), .sleep_active(act), .sleep_mode(mode),
    .sleep_refused(rf), .periph_clk_en(en), .comparator_mux_ok(cmp),
    .sys_reset(sysr), .start_at_vector(vec));
  sprc_core i_core (.clk(clk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .sleep_active(act), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sleep_instr(sins),
    .wake_event(wake));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task summarize;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      summarize();
    end
  end
  task chk(input string n, input logic [31:0] x, input logic [31:0] s);
    check_count++;
    if (s !== x)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, x, s);
    end
  endtask
  task rd(input logic [11:0] a);
    i_core.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    i_core.xfer(1'b1, a, d, q, e);
  endtask
  function logic [6:0] exp_a(input logic [7:0] g);
    return {~g[7], ~g[6] | asel, ~g[5], ~g[3], ~g[2], ~g[1], ~g[0]};
  endfunction
  task t_regs;
    rd(12'h140); chk("sleep_ctl", 0, q);
    rd(12'h144); chk("gate_a", 0, q);
    rd(12'h194); chk("gate_b", 0, q);
    rd(12'h1fc); chk("unmapped", 1, e);
    chk("en", 13'h1fff, en);
    $display("regs done");
  endtask
  task t_gate;
    logic [7:0] g;
    for (int i = 0; i < 8; i++)
    begin
      asel <= i[2];
      g = 32'h55AAFF00 >> (24 - 8 * i[1:0]);
      wr(12'h144, {24'h0, g});
      wr(12'h194, {24'h0, g});
      rd(12'h144); chk("gate_a", {24'h0, g & 8'hEF}, q);
      rd(12'h194); chk("gate_b", {24'h0, g & 8'h3F}, q);
      chk("en a", exp_a(g), en[6:0]);
      chk("en b", {~g[5:0]}, en[12:7]);
      chk("mux", {~g[0]}, cmp);
    end
    $display("gate done");
  endtask
  task t_sleep;
    logic r;
    for (int m = 0; m < 9; m++)
    begin
      i_core.slp(m[2:0], m < 8);
      @(posedge clk);
      r = m == 4 || m == 5 || m == 8;
      chk("refused", r, rf);
      chk("asleep", !r, act);
      if (!r)
      begin
        chk("mode", m, mode);
        @(posedge clk);
        chk("sleep en", m == 0 ? 13'h1fff : m == 1, en);
        i_core.wake();
        chk("awake", 0, act);
        chk("wake en", 13'h1fff, en);
      end
    end
    $display("sleep done");
  endtask
  task src(input int k, input logic v);
    case (k)
      0: por <= v;
      1: pin_b <= !v;
      2: wdt <= v;
      3: {sd_en, sd_low} <= {1'b1, v};
      4: scan <= v;
      default: {sd_en, sd_low} <= {1'b0, v};
    endcase
  endtask
  task t_reset;
    int n;
    logic v;
    for (int k = 0; k < 6; k++)
    begin
      fuse <= {1'b0, k[0]};
      wr(12'h144, 32'hFF);
      @(posedge clk);
      src(k, 1'b1);
      @(negedge clk);
      chk("reset", k != 5, sysr);
      @(posedge clk);
      src(k, 1'b0);
      n = 0;
      v = 1'b0;
      while (sysr !== 1'b0 && n < 50)
      begin
        @(posedge clk);
        n++;
        v = v | vec;
      end
      if (k != 5)
        chk("stretch", k[0] ? t1_ck + 2 : t0_ck + 2, n);
      chk("vector", k != 5, v);
      rd(12'h144);
      chk("gate_a", k == 5 ? 32'hEF : 0, q);
    end
    $display("reset done");
  endtask
  initial
  begin
    {por, wdt, sd_en, sd_low, scan, asel, rst_b} = '0;
    pin_b = 1'b1;
    fuse = 2'b00;
    mismatches = 0;
    check_count = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    while (sysr !== 1'b0)
      @(posedge clk);
    t_regs();
    t_gate();
    t_sleep();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
